/* File: src/sink_out_port.sv */
// sixteen channel current limited sinking output port with apb registers
//
// Overview of operation
// R1: each of channels 0..15 can be written alone through the channel set register
// R2: byte lanes write channels 7..0 and 15..8, highest channel in msb
// R3: a full word write covers channels 15..0, channel 15 in msb
// R4: user port and bus arbitrated only on same-cycle overlap, bus wins, fixed
// R5: status read chooses active, A or B threshold by its address
// R6: status read returns the module over-temperature flag
// R7: status read returns per-channel overcurrent flags since previous read, then clears
// R8: limit select codes per channel: keep, threshold A, threshold B, no limit
// R9: threshold A is an 8-bit code, current over 5.12 A times 256
// R10: threshold B is a separate 8-bit code with the same scaling
// R11: refresh period 2..255 recovers a tripped channel after period times 10 us
// R12: refresh period 0 keeps a tripped channel off until it is written again
// R13: refresh period 1 behaves as a 20 us period
// R14: run-time limit writes replace build-time defaults from then on
// R15: read-only module id, serial number and vendor id
// R16: over-threshold channel switches off at once; timer on 10 us ticks re-enables
`timescale 1ns/10ps
`include "sink_out_consts.svh"

module sink_out_port
  import sink_out_pkg::*;
#(
  parameter logic [31:0] MODULE_ID   = 32'h0000_5A5A, // arbitrary value
  parameter logic [31:0] SERIAL_NUM  = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] VENDOR_ID   = 32'h0000_00AB, // arbitrary value
  parameter logic [31:0] INIT_LIMIT  = 32'hFFFF_FFFF,
  parameter logic [7:0]  INIT_THR_A  = 8'hFF,
  parameter logic [7:0]  INIT_THR_B  = 8'hFF,
  parameter logic [7:0]  INIT_PERIOD = 8'h00
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // user logic write port
  input  wire user_wr_s         userWr,
  // pins
  input  wire logic [15:0][7:0] chanCurrent,
  input  wire logic             overTemp,
  output logic [15:0]           sinkOut,
  // interrupt
  output logic                  irq
);

  state_s s;
  state_s next_s;

  function automatic logic over(input logic [7:0] cur, input logic [7:0] thr);
    over = cur > thr;
  endfunction

  logic        accWr;
  logic        accRd;
  logic        setup;
  logic [15:0] apbMask;
  logic [15:0] apbData;
  logic [15:0] usrMask;
  logic [15:0] wrMask;
  logic [15:0] clrAct;
  logic [15:0] clrA;
  logic [15:0] clrB;
  logic [15:0] tripEv;
  logic [16:0] w1c;
  logic [7:0]  period;
  logic [7:0]  cur;
  logic [1:0]  sel;
  logic        overAct;

  always_comb begin
    next_s  = s;
    accWr   = psel & penable & s.pready & pwrite;
    accRd   = psel & penable & s.pready & ~pwrite;
    setup   = psel & ~penable;
    apbMask = 16'h0000;
    apbData = 16'h0000;
    clrAct  = 16'h0000;
    clrA    = 16'h0000;
    clrB    = 16'h0000;
    tripEv  = 16'h0000;
    w1c     = 17'h00000;
    cur     = 8'h00;
    sel     = `LIM_KEEP;
    overAct = 1'b0;
    // pin synchronisers
    next_s.curS1  = chanCurrent;
    next_s.curS2  = s.curS1;
    next_s.otS1   = overTemp;
    next_s.otS2   = s.otS1;
    next_s.otPrev = s.otS2;
    // 10 us timebase
    next_s.tick = 1'b0;
    if (s.tickCnt == 8'(`TICK_CYC - 1)) begin
      next_s.tickCnt = 8'h00;
      next_s.tick    = 1'b1;
    end else begin
      next_s.tickCnt = s.tickCnt + 8'h01;
    end
    // bus writes
    if (accWr) begin
      case (paddr)
        `ADDR_OUT_WORD: begin
          apbMask = {{8{pstrb[1]}}, {8{pstrb[0]}}}; // R2 R3
          apbData = pwdata[15:0]; // R3
        end
        `ADDR_CHAN_SET: begin
          apbMask = 16'h0001 << pwdata[`CHAN_IDX_LSB +: 4]; // R1
          apbData = {16{pwdata[`CHAN_VAL_BIT]}}; // R1
        end
        `ADDR_LIMIT_SEL: begin
          for (int i = 0; i < `CHANNELS; i++) begin
            if (pwdata[2*i +: 2] != `LIM_KEEP) begin // R8
              next_s.limSel[2*i +: 2] = pwdata[2*i +: 2]; // R14
            end
          end
        end
        `ADDR_THR_A: begin
          if (pstrb[0]) begin
            next_s.thrA = pwdata[7:0]; // R9 R14
          end
        end
        `ADDR_THR_B: begin
          if (pstrb[0]) begin
            next_s.thrB = pwdata[7:0]; // R10 R14
          end
        end
        `ADDR_REFRESH: begin
          if (pstrb[0]) begin
            next_s.refresh = pwdata[7:0];
          end
        end
        `ADDR_IRQ_STAT: w1c = pwdata[16:0];
        `ADDR_IRQ_MASK: next_s.irqMask = pwdata[16:0];
        default: ;
      endcase
    end
    // read clears exactly the flags that were returned
    if (accRd) begin
      case (paddr)
        `ADDR_STAT_ACT: clrAct = s.prdata[15:0]; // R7
        `ADDR_STAT_A:   clrA = s.prdata[15:0]; // R7
        `ADDR_STAT_B:   clrB = s.prdata[15:0]; // R7
        default: ;
      endcase
    end
    // merge with user port, bus wins on overlapping channels
    usrMask = userWr.valid ? userWr.mask : 16'h0000;
    wrMask  = apbMask | usrMask; // R4
    next_s.drv = (s.drv & ~wrMask) | (apbData & apbMask)
               | (userWr.data & usrMask & ~apbMask); // R4
    // effective refresh period
    period = (s.refresh == `REFRESH_ONE) ? `REFRESH_MIN : s.refresh; // R13
    for (int i = 0; i < `CHANNELS; i++) begin
      cur     = s.curS2[i];
      sel     = s.limSel[2*i +: 2];
      overAct = ((sel == `LIM_A) & over(cur, s.thrA))
              | ((sel == `LIM_B) & over(cur, s.thrB)); // R5
      next_s.ocA[i]   = (s.ocA[i] & ~clrA[i]) | over(cur, s.thrA); // R5 R7
      next_s.ocB[i]   = (s.ocB[i] & ~clrB[i]) | over(cur, s.thrB); // R5 R7
      next_s.ocAct[i] = (s.ocAct[i] & ~clrAct[i]) | overAct; // R7
      if (wrMask[i]) begin
        next_s.trip[i]  = 1'b0; // R12
        next_s.rfCnt[i] = 8'h00;
      end else if (s.sinkOut[i] & overAct) begin
        next_s.trip[i]  = 1'b1; // R16
        next_s.rfCnt[i] = 8'h00;
        tripEv[i]       = 1'b1;
      end else if (s.trip[i] && period != `REFRESH_OFF && s.tick) begin // R11 R12
        if (s.rfCnt[i] + 8'h01 >= period) begin
          next_s.trip[i]  = 1'b0; // R11 R16
          next_s.rfCnt[i] = 8'h00;
        end else begin
          next_s.rfCnt[i] = s.rfCnt[i] + 8'h01;
        end
      end
    end
    next_s.sinkOut = next_s.drv & ~next_s.trip; // R16
    // interrupts, new event wins over clear
    next_s.irqStat = (s.irqStat & ~w1c) | {s.otS2 & ~s.otPrev, tripEv};
    next_s.irq     = |(s.irqStat & s.irqMask);
    // apb answer, zero wait state, data captured in setup
    next_s.pready  = setup;
    next_s.pslverr = 1'b0;
    if (setup) begin
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        `ADDR_OUT_WORD:  next_s.prdata = {16'h0000, s.drv};
        `ADDR_CHAN_SET:  next_s.prdata = {16'h0000, s.sinkOut};
        `ADDR_LIMIT_SEL: next_s.prdata = s.limSel;
        `ADDR_THR_A:     next_s.prdata = {24'h000000, s.thrA};
        `ADDR_THR_B:     next_s.prdata = {24'h000000, s.thrB};
        `ADDR_REFRESH:   next_s.prdata = {24'h000000, s.refresh};
        `ADDR_STAT_ACT:  next_s.prdata = {15'h0000, s.otS2, s.ocAct}; // R5 R6
        `ADDR_STAT_A:    next_s.prdata = {15'h0000, s.otS2, s.ocA}; // R5 R6
        `ADDR_STAT_B:    next_s.prdata = {15'h0000, s.otS2, s.ocB}; // R5 R6
        `ADDR_IRQ_STAT:  next_s.prdata = {15'h0000, s.irqStat};
        `ADDR_IRQ_MASK:  next_s.prdata = {15'h0000, s.irqMask};
        `ADDR_MODULE_ID: next_s.prdata = MODULE_ID; // R15
        `ADDR_SERIAL:    next_s.prdata = SERIAL_NUM; // R15
        `ADDR_VENDOR:    next_s.prdata = VENDOR_ID; // R15
        default:         next_s.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s         <= '0;
      s.limSel  <= INIT_LIMIT;
      s.thrA    <= INIT_THR_A;
      s.thrB    <= INIT_THR_B;
      s.refresh <= INIT_PERIOD;
    end else begin
      s <= next_s;
    end
  end

  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign prdata  = s.prdata;
  assign sinkOut = s.sinkOut;
  assign irq     = s.irq;

  property p_trip_off;
    @(posedge clk_sys) disable iff (srst)
    s.trip[0] |-> !sinkOut[0];
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("tripped channel still on"); // R16

  property p_chan_set;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_CHAN_SET && pwdata[3:0] == 4'hD && !userWr.valid)
      |=> s.drv[13] == $past(pwdata[8]);
  endproperty
  a_chan_set: assert property (p_chan_set) else $error("single channel write lost"); // R1

  property p_low_byte;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_OUT_WORD && pstrb[1:0] == 2'h1 && !userWr.valid)
      |=> s.drv[15:8] == $past(s.drv[15:8]) && s.drv[7:0] == $past(pwdata[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte write wrong"); // R2

  property p_full_word;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_OUT_WORD && pstrb[1:0] == 2'h3)
      |=> s.drv == $past(pwdata[15:0]);
  endproperty
  a_full_word: assert property (p_full_word) else $error("full word write wrong"); // R3 R4

  property p_ready;
    @(posedge clk_sys) disable iff (srst)
    (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer not one cycle"); // zero wait state apb answer

  property p_overtemp;
    @(posedge clk_sys) disable iff (srst)
    (setup && paddr == `ADDR_STAT_A) |=> prdata[`OVERTEMP_BIT] == $past(s.otS2);
  endproperty
  a_overtemp: assert property (p_overtemp) else $error("overtemp flag not reported"); // R6

  property p_hold_off;
    @(posedge clk_sys) disable iff (srst)
    (s.trip[0] && s.refresh == `REFRESH_OFF && !wrMask[0]) |=> s.trip[0];
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("channel recovered without refresh"); // R12

  property p_keep;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_LIMIT_SEL && pwdata[1:0] == `LIM_KEEP)
      |=> s.limSel[1:0] == $past(s.limSel[1:0]);
  endproperty
  a_keep: assert property (p_keep) else $error("keep code changed a limit"); // R8

  property p_thr_b;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_THR_B && pstrb[0]) |=> s.thrB == $past(pwdata[7:0]);
  endproperty
  a_thr_b: assert property (p_thr_b) else $error("threshold b not stored"); // R10 R14

  property p_irq;
    @(posedge clk_sys) disable iff (srst)
    ##1 irq == |($past(s.irqStat) & $past(s.irqMask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow status and mask"); // R16

  property p_high_byte;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_OUT_WORD && pstrb[1:0] == 2'h2 && !userWr.valid)
      |=> s.drv[7:0] == $past(s.drv[7:0]) && s.drv[15:8] == $past(pwdata[15:8]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte write wrong"); // R2

  property p_user_write;
    @(posedge clk_sys) disable iff (srst)
    (userWr.valid && !accWr)
      |=> s.drv == (($past(s.drv) & ~$past(userWr.mask))
                 | ($past(userWr.data) & $past(userWr.mask)));
  endproperty
  a_user_write: assert property (p_user_write) else $error("user write lost"); // R4

  property p_bus_wins;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_OUT_WORD && userWr.valid)
      |=> (s.drv & $past(apbMask)) == ($past(pwdata[15:0]) & $past(apbMask));
  endproperty
  a_bus_wins: assert property (p_bus_wins) else $error("user write beat the bus"); // R4

  property p_trip;
    @(posedge clk_sys) disable iff (srst)
    (s.sinkOut[0] && s.limSel[1:0] == `LIM_A && s.curS2[0] > s.thrA && !wrMask[0])
      |=> s.trip[0] && !sinkOut[0];
  endproperty
  a_trip: assert property (p_trip) else $error("overcurrent did not switch off"); // R16

  property p_refresh_one;
    @(posedge clk_sys) disable iff (srst)
    (s.trip[0] && s.refresh == `REFRESH_ONE && s.tick && s.rfCnt[0] == 8'h00 && !wrMask[0])
      |=> s.trip[0] && s.rfCnt[0] == 8'h01;
  endproperty
  a_refresh_one: assert property (p_refresh_one) else $error("period one too short"); // R13

  property p_refresh_end;
    @(posedge clk_sys) disable iff (srst)
    (s.trip[0] && s.refresh >= `REFRESH_MIN && s.tick && !wrMask[0]
      && s.rfCnt[0] + 8'h01 >= s.refresh) |=> !s.trip[0];
  endproperty
  a_refresh_end: assert property (p_refresh_end) else $error("no recovery at period"); // R11

  property p_thr_a;
    @(posedge clk_sys) disable iff (srst)
    (accWr && paddr == `ADDR_THR_A && pstrb[0]) |=> s.thrA == $past(pwdata[7:0]);
  endproperty
  a_thr_a: assert property (p_thr_a) else $error("threshold a not stored"); // R9 R14

  property p_write_clear;
    @(posedge clk_sys) disable iff (srst)
    wrMask[0] |=> !s.trip[0];
  endproperty
  a_write_clear: assert property (p_write_clear) else $error("write left channel tripped"); // R12

endmodule

/* File: src/sink_out_consts.svh */
// offsets, field positions, limit and refresh codes and timing counts of the sink output port
`ifndef SINK_OUT_CONSTS_SVH
`define SINK_OUT_CONSTS_SVH

`define CLK_MHZ        20
`define TICK_US        10
`define TICK_CYC       (`TICK_US * `CLK_MHZ)
`define CHANNELS       16

`define ADDR_OUT_WORD  12'h000
`define ADDR_CHAN_SET  12'h004
`define ADDR_LIMIT_SEL 12'h008
`define ADDR_THR_A     12'h00C
`define ADDR_THR_B     12'h010
`define ADDR_REFRESH   12'h014
`define ADDR_STAT_ACT  12'h018
`define ADDR_STAT_A    12'h01C
`define ADDR_STAT_B    12'h020
`define ADDR_IRQ_STAT  12'h024
`define ADDR_IRQ_MASK  12'h028
`define ADDR_MODULE_ID 12'h02C
`define ADDR_SERIAL    12'h030
`define ADDR_VENDOR    12'h034

`define CHAN_IDX_LSB   0
`define CHAN_VAL_BIT   8
`define OVERTEMP_BIT   16

`define LIM_KEEP       2'h0
`define LIM_A          2'h1
`define LIM_B          2'h2
`define LIM_NONE       2'h3

`define REFRESH_OFF    8'h00
`define REFRESH_ONE    8'h01
`define REFRESH_MIN    8'h02

`endif

/* File: src/sink_out_pkg.sv */
// types of the sink output port
package sink_out_pkg;

  typedef struct packed {
    logic        valid;
    logic [15:0] mask;
    logic [15:0] data;
  } user_wr_s;

  typedef struct packed {
    logic [15:0]       drv;
    logic [15:0]       trip;
    logic [31:0]       limSel;
    logic [7:0]        thrA;
    logic [7:0]        thrB;
    logic [7:0]        refresh;
    logic [15:0]       ocAct;
    logic [15:0]       ocA;
    logic [15:0]       ocB;
    logic [16:0]       irqStat;
    logic [16:0]       irqMask;
    logic [7:0]        tickCnt;
    logic              tick;
    logic [15:0][7:0]  rfCnt;
    logic [15:0][7:0]  curS1;
    logic [15:0][7:0]  curS2;
    logic              otS1;
    logic              otS2;
    logic              otPrev;
    logic [15:0]       sinkOut;
    logic              irq;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } state_s;

endpackage

/* File: dv/sink_load.sv */
// resistive load model on the sinking outputs
`timescale 1ns/10ps

module sink_load
  import sink_out_pkg::*;
(
  // channel state and load setting
  input  wire logic [15:0]      sinkOut,
  input  wire logic [15:0][7:0] load,
  // sensed current
  output logic [15:0][7:0]      chanCurrent
);
  // current only flows through a channel that sinks
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      chanCurrent[i] = sinkOut[i] ? load[i] : 8'h00;
    end
  end
endmodule

/* File: dv/current_limited_sink_output_tb.sv */
// self-checking bench of the sink output port
`timescale 1ns/10ps
`include "sink_out_consts.svh"

module current_limited_sink_output_tb
  import sink_out_pkg::*;
;
  localparam logic [31:0] ID_MOD = 32'h0000_1357; // arbitrary value
  localparam logic [31:0] ID_SER = 32'h0000_2468; // arbitrary value
  localparam logic [31:0] ID_VEN = 32'h0000_0C0D; // arbitrary value
  logic             clk_sys, srst, psel, penable, pwrite, pready, pslverr, overTemp, irq;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rdData;
  logic [3:0]       pstrb;
  logic             rdErr;
  user_wr_s         userWr;
  logic [15:0][7:0] load, chanCurrent;
  logic [15:0]      sinkOut;
  int               n_fail, total_checks, n, pe;

  sink_out_port #(.MODULE_ID(ID_MOD), .SERIAL_NUM(ID_SER), .VENDOR_ID(ID_VEN)) u_sink_out_port (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .userWr(userWr), .chanCurrent(chanCurrent), .overTemp(overTemp),
    .sinkOut(sinkOut), .irq(irq));
  sink_load u_sink_load (.sinkOut(sinkOut), .load(load), .chanCurrent(chanCurrent));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; optional user write lands on the access edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input user_wr_s u);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    userWr <= u;
    k = 0;
    do begin
      @(posedge clk_sys);
      userWr <= '0;
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    xfer(1'b1, a, d, s, '0);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0, '0);
    chk(rdData, e);
  endtask

  task automatic waitOut(input int ch, input logic v, input int lim);
    n = 0;
    while (sinkOut[ch] !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (sinkOut[ch] !== v) begin
      n_fail++;
      results();
    end
  endtask

  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, overTemp} = '0;
    {paddr, pwdata, pstrb} = '0;
    userWr = '0;
    load = '0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rdchk(`ADDR_LIMIT_SEL, 32'hFFFF_FFFF);
    rdchk(`ADDR_THR_A, 32'h0000_00FF);
    rdchk(`ADDR_THR_B, 32'h0000_00FF);
    rdchk(`ADDR_REFRESH, 32'h0000_0000);
    wr(`ADDR_MODULE_ID, 32'h0000_0000, 4'hF);
    rdchk(`ADDR_MODULE_ID, ID_MOD);
    rdchk(`ADDR_SERIAL, ID_SER);
    rdchk(`ADDR_VENDOR, ID_VEN);
    rdchk(12'h03C, 32'h0000_0000);
    chk({31'h0, rdErr}, 32'h1);
    // word, byte lanes, single channels, user port, collision
    wr(`ADDR_OUT_WORD, 32'h0000_A5C3, 4'h3);
    rdchk(`ADDR_CHAN_SET, 32'h0000_A5C3);
    wr(`ADDR_OUT_WORD, 32'h0000_3C00, 4'h2);
    rdchk(`ADDR_CHAN_SET, 32'h0000_3CC3);
    wr(`ADDR_OUT_WORD, 32'h0000_0012, 4'h1);
    rdchk(`ADDR_CHAN_SET, 32'h0000_3C12);
    wr(`ADDR_CHAN_SET, 32'h0000_000D, 4'hF);
    wr(`ADDR_CHAN_SET, 32'h0000_0100, 4'hF);
    rdchk(`ADDR_CHAN_SET, 32'h0000_1C13);
    userWr <= '{1'b1, 16'hFF00, 16'h8100};
    @(posedge clk_sys);
    userWr <= '0;
    rdchk(`ADDR_CHAN_SET, 32'h0000_8113);
    xfer(1'b1, `ADDR_OUT_WORD, 32'h0000_0000, 4'h1, '{1'b1, 16'h0201, 16'h0201});
    rdchk(`ADDR_CHAN_SET, 32'h0000_8300);
    // limits and overcurrent status
    wr(`ADDR_THR_A, 32'h0000_0040, 4'h1);
    wr(`ADDR_THR_B, 32'h0000_0080, 4'h1);
    wr(`ADDR_LIMIT_SEL, 32'h0000_0039, 4'hF);
    wr(`ADDR_LIMIT_SEL, 32'h0000_0000, 4'hF);
    rdchk(`ADDR_LIMIT_SEL, 32'hFFFF_FFF9);
    rdchk(`ADDR_STAT_ACT, 32'h0000_0000);
    load[0] <= 8'h60;
    load[1] <= 8'h60;
    load[2] <= 8'h60;
    wr(`ADDR_OUT_WORD, 32'h0000_0007, 4'h3);
    waitOut(0, 1'b0, 20);
    rdchk(`ADDR_CHAN_SET, 32'h0000_0006);
    rdchk(`ADDR_STAT_ACT, 32'h0000_0001);
    rdchk(`ADDR_STAT_A, 32'h0000_0007);
    rdchk(`ADDR_STAT_B, 32'h0000_0000);
    rdchk(`ADDR_STAT_ACT, 32'h0000_0000);
    repeat (600) @(posedge clk_sys);
    rdchk(`ADDR_CHAN_SET, 32'h0000_0006);
    load[0] <= 8'h00;
    wr(`ADDR_CHAN_SET, 32'h0000_0100, 4'hF);
    rdchk(`ADDR_CHAN_SET, 32'h0000_0007);
    // interrupts: trip event, over-temperature, mask, clear
    rdchk(`ADDR_IRQ_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    wr(`ADDR_IRQ_MASK, 32'h0001_FFFF, 4'hF);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(`ADDR_IRQ_STAT, 32'h0000_0001, 4'hF);
    rdchk(`ADDR_IRQ_STAT, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    overTemp <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdchk(`ADDR_STAT_ACT, 32'h0001_0000);
    chk({31'h0, irq}, 32'h1);
    overTemp <= 1'b0;
    wr(`ADDR_IRQ_STAT, 32'h0001_0000, 4'hF);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    // automatic recovery after period ticks of 200 cycles
    for (int p = 1; p <= 3; p += 2) begin
      pe = (p == 1) ? 2 : p;
      wr(`ADDR_REFRESH, p, 4'h1);
      wr(`ADDR_CHAN_SET, 32'h0000_0100, 4'hF);
      load[0] <= 8'h60;
      waitOut(0, 1'b0, 20);
      waitOut(0, 1'b1, 1000);
      chk({31'h0, (n >= (pe - 1) * 200 && n <= pe * 200 + 6)}, 32'h1);
      load[0] <= 8'h00;
      repeat (5) @(posedge clk_sys);
    end
    results();
  end
endmodule
